//--- core/bus_trigger_consts.vh
`ifndef BUS_TRIGGER_CONSTS_VH
`define BUS_TRIGGER_CONSTS_VH

// Register byte addresses on the APB slave.
`define REG_CTRL        12'h000
`define REG_ADDR_MIN    12'h004
`define REG_ADDR_MAX    12'h008
`define REG_DATA_HI     12'h00c
`define REG_DATA_LO     12'h010
`define REG_DATA_CFG    12'h014
`define REG_FILT_CTRL   12'h018
`define REG_FILT_DATA   12'h01c
`define REG_FILT_INDEX  12'h020
`define REG_STATUS      12'h024
`define REG_FRAME_INFO  12'h028
`define REG_FRAME_TIME  12'h02c
`define REG_FIELD_INFO  12'h030
`define REG_FIELD_TIME  12'h034
`define REG_TIME_NOW    12'h038

// Control register fields.
`define CTRL_TYPE_LSB   0
`define CTRL_TYPE_MSB   2
`define CTRL_ADDR10_BIT 3
`define CTRL_DIR_LSB    4
`define CTRL_DIR_MSB    5
`define CTRL_AOP_LSB    6
`define CTRL_AOP_MSB    7
`define CTRL_ANACK_BIT  8
`define CTRL_WNACK_BIT  9
`define CTRL_RNACK_BIT  10
`define CTRL_RESET_VAL  32'h0000_0000

// Trigger types.
`define TRIG_START      3'h0
`define TRIG_RESTART    3'h1
`define TRIG_STOP       3'h2
`define TRIG_NACK       3'h3
`define TRIG_ADDR       3'h4
`define TRIG_DATA       3'h5
`define TRIG_ADDR_DATA  3'h6

// Direction selection.
`define DIR_EITHER      2'h0
`define DIR_READ        2'h1
`define DIR_WRITE       2'h2

// Comparison operators.
`define OP_EQUAL        2'h0
`define OP_IN_RANGE     2'h1
`define OP_OUT_RANGE    2'h2
`define OP_NOT_EQUAL    2'h3

// Ten-bit address prefix in the first address byte.
`define TEN_BIT_PREFIX  5'h1e

`endif

//--- core/i2c_bus_trigger_decoder.v
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "bus_trigger_consts.vh"

// Summary of operation
// R1: Start is data falling while clock high.
// R2: Start trigger at the data falling edge.
// R3: Start without stop since is repeated start.
// R4: Stop is data rising while clock high.
// R5: Missing acknowledge: data high at ninth pulse.
// R6: Address trigger at falling edge ending acknowledge.
// R7: Three separately enabled missing-acknowledge sources.
// R8: Read-end missing acknowledge is no error.
// R9: Address length select picks 7 or 10 bits.
// R10: Direction restricts to read, write or either.
// R11: Address equality, in-range, out-of-range compare.
// R12: Data pattern msb first, 64 bits, bytewise.
// R13: Skip count sets data bytes ignored first.
// R14: Combined mode needs address and data match.
// R15: Filter reports only matching frames; a frame cut short by capture end is reported without the filter.
// R16: Filter fields enabled individually.
// R17: Data and index filters use operator ranges; the index filter takes filt_index[15:8] as both limits.
// R18: Incomplete frame gets insufficient-length state.
// R19: Frame reports index, start, length, address, direction.
// R20: Field reports index, byte, acknowledge time and value.
// R21: Direction bit one reads, zero writes.
// R22: Ten-bit address recognised by reserved prefix.
// R23: Ten-bit read accepts repeated first byte.
// R24: Lines synchronised, edges found before conditions.
// R25: Trigger is one-cycle pulse; reset to idle.
module i2c_bus_trigger_decoder #(
    parameter PATTERN_BYTES = 8
) (
    input wire clk_i,
    input wire rstn_i,
    input wire [11:0] paddr_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire scl_i,
    input wire sda_i,
    input wire capture_end_i,
    output reg trigger_o,
    output reg frame_valid_o,
    output reg field_valid_o,
    output reg error_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_DATA = 2'h2;

    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg scl_d;
    reg sda_d;
    reg [1:0] state;
    reg in_msg;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg [1:0] addr_byte;
    reg ten_bit;
    reg [9:0] addr;
    reg rw;
    reg addr_hit;
    reg data_hit;
    reg [7:0] data_index;
    reg [3:0] pat_pos;
    reg ack_pending;
    reg ack_sampled;
    reg [31:0] ack_time;
    reg [31:0] timer;
    reg [31:0] ctrl;
    reg [9:0] addr_min;
    reg [9:0] addr_max;
    reg [63:0] pattern;
    reg [15:0] data_cfg;
    reg [7:0] filt_ctrl;
    reg [15:0] filt_data;
    reg [15:0] filt_index;
    reg [15:0] frame_count;
    reg [31:0] frame_time;
    reg [31:0] frame_info;
    reg [31:0] field_info;
    reg [31:0] field_time;
    reg frame_fail;
    reg [31:0] rdata;

    wire scl_rise = scl_sync[1] & ~scl_d;
    wire scl_fall = ~scl_sync[1] & scl_d;
    wire start_cond = scl_sync[1] & scl_d & ~sda_sync[1] & sda_d; // [R1] [R24]
    wire stop_cond = scl_sync[1] & scl_d & sda_sync[1] & ~sda_d; // [R4] [R24]
    wire [2:0] trig_type = ctrl[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];
    wire [1:0] dir_sel = ctrl[`CTRL_DIR_MSB:`CTRL_DIR_LSB];
    wire [1:0] addr_op = ctrl[`CTRL_AOP_MSB:`CTRL_AOP_LSB];
    wire address_length_select = ctrl[`CTRL_ADDR10_BIT];
    wire address_nack_enable = ctrl[`CTRL_ANACK_BIT];
    wire write_data_nack_enable = ctrl[`CTRL_WNACK_BIT];
    wire read_data_nack_enable = ctrl[`CTRL_RNACK_BIT];
    wire [7:0] data_skip_count = data_cfg[7:0];
    wire [3:0] pattern_len = data_cfg[11:8];
    wire [1:0] data_op = data_cfg[13:12];
    wire filter_enable = filt_ctrl[0];
    wire [7:0] cur_byte = {shreg[6:0], sda_sync[1]};

    // Compare a value against one or two limits with the chosen operator.
    function cmp_op;
        input [1:0] op;
        input [9:0] val;
        input [9:0] lo;
        input [9:0] hi;
        begin
            case (op)
                `OP_EQUAL: cmp_op = (val == lo);
                `OP_IN_RANGE: cmp_op = (val >= lo) && (val <= hi);
                `OP_OUT_RANGE: cmp_op = (val < lo) || (val > hi);
                default: cmp_op = (val != lo);
            endcase
        end
    endfunction

    // The address byte being closed is taken from the shifter, since addr and rw load at that same edge.
    wire [9:0] addr_now = (addr_byte == 2'h0) ? {3'h0, shreg[7:1]} :
                          ((addr_byte == 2'h1) ? {addr[9:8], shreg} : addr);
    wire rw_now = (addr_byte == 2'h1) ? rw : shreg[0]; // [R21]
    wire dir_ok = (dir_sel == `DIR_EITHER) || (dir_sel == `DIR_READ && rw_now) ||
                  (dir_sel == `DIR_WRITE && !rw_now); // [R10] [R21]
    wire [9:0] addr_cmp = address_length_select ? addr_now : {3'h0, addr_now[6:0]}; // [R9]
    wire addr_match = (ten_bit == address_length_select) && dir_ok &&
                      cmp_op(addr_op, addr_cmp, addr_min, addr_max); // [R11]
    wire [5:0] pat_sel = {pat_pos[2:0], 3'h0};
    wire [7:0] pat_byte = pattern[63 - pat_sel -: 8]; // [R12]

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            timer <= 32'h0;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
            timer <= timer + 32'h1;
        end
    end

    // Decoder. Bits are sampled on clock rising edges; events fire on edges.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE; // [R25]
            in_msg <= 1'b0;
            bitcnt <= 4'h0;
            shreg <= 8'h0;
            addr_byte <= 2'h0;
            ten_bit <= 1'b0;
            addr <= 10'h0;
            rw <= 1'b0;
            addr_hit <= 1'b0;
            data_hit <= 1'b0;
            data_index <= 8'h0;
            pat_pos <= 4'h0;
            ack_pending <= 1'b0;
            ack_sampled <= 1'b0;
            ack_time <= 32'h0;
            trigger_o <= 1'b0;
            frame_valid_o <= 1'b0;
            field_valid_o <= 1'b0;
            error_o <= 1'b0;
            frame_count <= 16'h0;
            frame_time <= 32'h0;
            frame_info <= 32'h0;
            field_info <= 32'h0;
            field_time <= 32'h0;
            frame_fail <= 1'b0;
        end else begin
            trigger_o <= 1'b0; // [R25]
            frame_valid_o <= 1'b0;
            field_valid_o <= 1'b0;
            error_o <= 1'b0;
            if (start_cond) begin
                // Trigger pulses in the cycle after the sampled data edge. [R2]
                if ((trig_type == `TRIG_START && !in_msg) ||
                    (trig_type == `TRIG_RESTART && in_msg)) // [R3]
                    trigger_o <= 1'b1;
                in_msg <= 1'b1;
                state <= ST_ADDR;
                bitcnt <= 4'h0;
                ack_pending <= 1'b0;
                data_index <= 8'h0;
                pat_pos <= 4'h0;
                data_hit <= 1'b0;
                frame_fail <= 1'b0;
                // A restart after a ten-bit write keeps the address for the read. [R23]
                if (!(in_msg && ten_bit && addr_byte == 2'h2)) begin
                    addr_byte <= 2'h0;
                    ten_bit <= 1'b0;
                    addr_hit <= 1'b0;
                end
                if (!in_msg)
                    frame_time <= timer;
            end else if (stop_cond) begin
                if (trig_type == `TRIG_STOP)
                    trigger_o <= 1'b1; // [R4]
                in_msg <= 1'b0;
                state <= ST_IDLE;
            end else if (state != ST_IDLE && scl_rise) begin
                if (bitcnt == 4'h8) begin
                    ack_sampled <= sda_sync[1];
                    ack_time <= timer;
                    ack_pending <= 1'b1;
                end else begin
                    shreg <= cur_byte;
                    bitcnt <= bitcnt + 4'h1;
                end
            end else if (state != ST_IDLE && scl_fall) begin
                // The fall that ends a start's hold finds no acknowledge pending and counts nothing.
                if (ack_pending) begin
                    bitcnt <= 4'h0;
                    ack_pending <= 1'b0;
                    field_valid_o <= 1'b1; // [R20]
                    field_info <= {ack_sampled, 7'h0, data_index, 8'h0, shreg};
                    field_time <= ack_time;
                    if (state == ST_ADDR) begin
                        if (addr_byte == 2'h0) begin
                            rw <= shreg[0]; // [R21]
                            if (shreg[7:3] == `TEN_BIT_PREFIX) begin // [R22]
                                ten_bit <= 1'b1;
                                addr[9:8] <= shreg[2:1];
                                addr_byte <= 2'h1;
                            end else begin
                                addr <= {3'h0, shreg[7:1]};
                                state <= ST_DATA;
                                addr_byte <= 2'h3;
                            end
                        end else if (addr_byte == 2'h1) begin
                            addr[7:0] <= shreg;
                            addr_byte <= 2'h2;
                            state <= ST_DATA;
                        end else begin
                            rw <= shreg[0]; // [R23]
                            state <= ST_DATA;
                        end
                        if (ack_sampled && address_nack_enable && trig_type == `TRIG_NACK)
                            trigger_o <= 1'b1; // [R5] [R7]
                        if (ack_sampled)
                            error_o <= 1'b1;
                    end else begin
                        data_index <= data_index + 8'h1;
                        if (ack_sampled && trig_type == `TRIG_NACK &&
                            ((!rw && write_data_nack_enable) || (rw && read_data_nack_enable)))
                            trigger_o <= 1'b1; // [R5] [R7]
                        if (ack_sampled && !rw)
                            error_o <= 1'b1; // [R8]
                        if (data_index >= data_skip_count && !data_hit && pat_pos < pattern_len) begin // [R13]
                            if ((data_op == `OP_EQUAL) == (shreg == pat_byte)) begin
                                if (pat_pos + 4'h1 == pattern_len) begin
                                    data_hit <= 1'b1;
                                    if (trig_type == `TRIG_DATA ||
                                        (trig_type == `TRIG_ADDR_DATA && addr_hit)) // [R14]
                                        trigger_o <= 1'b1;
                                end
                                pat_pos <= pat_pos + 4'h1;
                            end else begin
                                pat_pos <= 4'h0;
                            end
                        end
                    end
                end
            end
            // Address trigger at the falling edge that closes the address acknowledge.
            if (!start_cond && !stop_cond && scl_fall && state == ST_ADDR && ack_pending &&
                (addr_byte == 2'h0 ? shreg[7:3] != `TEN_BIT_PREFIX : 1'b1)) begin
                frame_valid_o <= !filter_enable || filt_pass(shreg); // [R15] [R19]
                frame_count <= frame_count + 16'h1;
                frame_info <= {frame_count[7:0], 1'b0, frame_fail, 4'h0, ten_bit, rw_now, 6'h0, addr_now};
                if (addr_match) begin
                    addr_hit <= 1'b1;
                    if (trig_type == `TRIG_ADDR)
                        trigger_o <= 1'b1; // [R6]
                end
            end
            // A capture that ends mid-frame marks the frame as too short.
            if (capture_end_i && in_msg && !frame_fail) begin
                frame_fail <= 1'b1;
                frame_info[22] <= 1'b1; // [R18]
                frame_valid_o <= 1'b1;
            end
        end
    end

    // Filter: each field condition is enabled on its own bit.
    function filt_pass;
        input [7:0] b;
        reg a_ok;
        reg r_ok;
        reg k_ok;
        reg d_ok;
        reg i_ok;
        begin
            a_ok = !filt_ctrl[1] || cmp_op(`OP_EQUAL, addr_cmp, addr_min, addr_max); // [R16]
            r_ok = !filt_ctrl[2] || (rw_now == filt_ctrl[6]);
            k_ok = !filt_ctrl[3] || (ack_sampled == filt_ctrl[7]);
            d_ok = !filt_ctrl[4] || cmp_op(filt_ctrl[6:5], {2'h0, b}, {2'h0, filt_data[7:0]},
                                            {2'h0, filt_data[15:8]}); // [R17]
            i_ok = !filt_ctrl[5] || cmp_op(filt_index[1:0], {2'h0, data_index},
                                            {2'h0, filt_index[15:8]}, {2'h0, filt_index[15:8]});
            filt_pass = a_ok && r_ok && k_ok && d_ok && i_ok;
        end
    endfunction

    // APB slave: zero wait states, unmapped addresses read zero with an error.
    wire apb_wr = psel_i & penable_i & pwrite_i;
    reg mapped;
    always @* begin
        mapped = 1'b1;
        case (paddr_i)
            `REG_CTRL: rdata = ctrl;
            `REG_ADDR_MIN: rdata = {22'h0, addr_min};
            `REG_ADDR_MAX: rdata = {22'h0, addr_max};
            `REG_DATA_HI: rdata = pattern[63:32];
            `REG_DATA_LO: rdata = pattern[31:0];
            `REG_DATA_CFG: rdata = {16'h0, data_cfg};
            `REG_FILT_CTRL: rdata = {24'h0, filt_ctrl};
            `REG_FILT_DATA: rdata = {16'h0, filt_data};
            `REG_FILT_INDEX: rdata = {16'h0, filt_index};
            `REG_STATUS: rdata = {24'h0, data_hit, addr_hit, ten_bit, rw, in_msg, 1'b0, state};
            `REG_FRAME_INFO: rdata = frame_info;
            `REG_FRAME_TIME: rdata = frame_time;
            `REG_FIELD_INFO: rdata = field_info;
            `REG_FIELD_TIME: rdata = field_time;
            `REG_TIME_NOW: rdata = timer;
            default: begin
                rdata = 32'h0;
                mapped = 1'b0;
            end
        endcase
    end
    assign prdata_o = rdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl <= `CTRL_RESET_VAL;
            addr_min <= 10'h0;
            addr_max <= 10'h0;
            pattern <= 64'h0;
            data_cfg <= 16'h0100;
            filt_ctrl <= 8'h0;
            filt_data <= 16'h0;
            filt_index <= 16'h0;
        end else if (apb_wr) begin
            case (paddr_i)
                `REG_CTRL: ctrl <= pwdata_i;
                `REG_ADDR_MIN: addr_min <= pwdata_i[9:0];
                `REG_ADDR_MAX: addr_max <= pwdata_i[9:0];
                `REG_DATA_HI: pattern[63:32] <= pwdata_i;
                `REG_DATA_LO: pattern[31:0] <= pwdata_i;
                `REG_DATA_CFG: data_cfg <= pwdata_i[15:0];
                `REG_FILT_CTRL: filt_ctrl <= pwdata_i[7:0];
                `REG_FILT_DATA: filt_data <= pwdata_i[15:0];
                `REG_FILT_INDEX: filt_index <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- sim/i2c_bus_trigger_decoder_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "bus_trigger_consts.vh"
module i2c_bus_trigger_decoder_properties #(
    parameter PATTERN_BYTES = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic capture_end_i,
    input wire logic trigger_o,
    input wire logic frame_valid_o,
    input wire logic field_valid_o,
    input wire logic error_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [2:0] trig_type;
    logic sda_q;
    logic busy;
    logic [3:0] since_start;
    // Conditions are judged on raw pins; the design sees them a few cycles later through its synchroniser.
    wire start_now = scl_i && sda_q && !sda_i;
    wire stop_now = scl_i && !sda_q && sda_i;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_type <= 3'h0;
            sda_q <= 1'b1;
            busy <= 1'b0;
            since_start <= 4'hf;
        end else begin
            sda_q <= sda_i;
            if (psel_i && penable_i && pwrite_i && pready_o && paddr_i == `REG_CTRL) begin
                trig_type <= pwdata_i[2:0];
            end
            if (start_now) begin
                busy <= 1'b1;
            end else if (stop_now) begin
                busy <= 1'b0;
            end
            if (start_now) begin
                since_start <= 4'h0;
            end else if (since_start != 4'hf) begin
                since_start <= since_start + 4'h1;
            end
        end
    end
    chk_trig_single: assert property (trigger_o |=> !trigger_o) else $error("trigger wider than one cycle");
    chk_err_single: assert property (error_o |=> !error_o) else $error("error wider than one cycle");
    chk_frame_single: assert property (frame_valid_o |=> !frame_valid_o) else $error("frame pulse too wide");
    chk_ready_now: assert property (psel_i && penable_i |-> pready_o) else $error("access not answered at once");
    chk_bad_addr: assert property (psel_i && penable_i && paddr_i > 12'h038 |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    chk_good_addr: assert property (psel_i && penable_i && paddr_i <= 12'h038 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
        else $error("mapped access refused");
    chk_start_fires: assert property (start_now && !busy && trig_type == `TRIG_START |-> ##[1:6] trigger_o)
        else $error("start did not trigger");
    chk_start_cause: assert property (trigger_o && trig_type == `TRIG_START |-> since_start <= 4'h6)
        else $error("start trigger without a start");
    chk_stop_fires: assert property (stop_now && trig_type == `TRIG_STOP |-> ##[1:6] trigger_o)
        else $error("stop did not trigger");
    chk_quiet_reset: assert property ($rose(rstn_i) |-> !trigger_o && !error_o && !frame_valid_o)
        else $error("output active after reset");
endmodule
`default_nettype wire

//--- sim/i2c_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_model (
    input wire logic clk_i,
    output var logic scl_o,
    output var logic sda_o
);
    // Both lines are pulled up, so idle and released means high; the clock stands still between frames.
    logic busy = 1'b0;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic put_bit(input logic b);
        scl_o <= 1'b0;
        wt(2);
        sda_o <= b;
        wt(2);
        scl_o <= 1'b1;
        wt(4);
    endtask
    task automatic start_c;
        if (busy) begin
            scl_o <= 1'b0;
            wt(2);
            sda_o <= 1'b1;
            wt(2);
            scl_o <= 1'b1;
            wt(4);
        end
        sda_o <= 1'b0;
        wt(4);
        busy = 1'b1;
    endtask
    task automatic put_byte(input logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        put_bit(nack);
    endtask
    task automatic stop_c;
        scl_o <= 1'b0;
        wt(2);
        sda_o <= 1'b0;
        wt(2);
        scl_o <= 1'b1;
        wt(4);
        sda_o <= 1'b1;
        wt(4);
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/i2c_bus_trigger_decoder_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "bus_trigger_consts.vh"
module i2c_bus_trigger_decoder_test;
    logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, capture_end_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q;
    logic pready_o, pslverr_o, trigger_o, frame_valid_o, field_valid_o, error_o, e;
    wire scl, sda;
    int fail_count = 0, check_count = 0, n_trig, n_err, n_fld, n_frm;
    typedef struct {logic [31:0] ctrl; logic [31:0] amin; logic [31:0] amax; logic [31:0] dhi; int seq; int trig;} row_t;
    row_t rows[19] = '{'{32'h0, 0, 0, 0, 0, 1}, '{32'h1, 0, 0, 0, 0, 0}, '{32'h1, 0, 0, 0, 1, 1},
        '{32'h2, 0, 0, 0, 1, 1}, '{32'h403, 0, 0, 0, 1, 1}, '{32'h103, 0, 0, 0, 1, 0}, '{32'h203, 0, 0, 0, 2, 1},
        '{32'h403, 0, 0, 0, 2, 0}, '{32'h4, 32'h50, 0, 0, 0, 1}, '{32'h14, 32'h50, 0, 0, 0, 0},
        '{32'h24, 32'h50, 0, 0, 0, 1}, '{32'h44, 32'h40, 32'h5f, 0, 0, 1}, '{32'h84, 32'h40, 32'h5f, 0, 0, 0},
        '{32'hc, 32'h223, 0, 0, 3, 1}, '{32'h5, 0, 0, 32'h5a000000, 0, 1}, '{32'h5, 0, 0, 32'h5b000000, 0, 0},
        '{32'h6, 32'h50, 0, 32'h5a000000, 0, 1}, '{32'h6, 32'h51, 0, 32'h5a000000, 0, 0}, '{32'h14, 32'h50, 0, 0, 1, 1}};
    i2c_bus_model u_bus (.clk_i(clk_i), .scl_o(scl), .sda_o(sda));
    i2c_bus_trigger_decoder #(.PATTERN_BYTES(8)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .paddr_i(paddr_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .scl_i(scl), .sda_i(sda), .capture_end_i(capture_end_i),
        .trigger_o(trigger_o), .frame_valid_o(frame_valid_o), .field_valid_o(field_valid_o), .error_o(error_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        n_trig += (trigger_o === 1'b1);
        n_err += (error_o === 1'b1);
        n_fld += (field_valid_o === 1'b1);
        n_frm += (frame_valid_o === 1'b1);
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i);
        while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic run_seq(input int s);
        n_trig = 0;
        n_err = 0;
        n_fld = 0;
        n_frm = 0;
        u_bus.start_c();
        u_bus.put_byte(s == 3 ? 8'hf4 : 8'ha0, 1'b0);
        u_bus.put_byte(s == 3 ? 8'h23 : 8'h5a, s == 2);
        if (s == 1) begin
            u_bus.start_c();
            u_bus.put_byte(8'ha1, 1'b0);
            u_bus.put_byte(8'h3c, 1'b1);
        end
        u_bus.stop_c();
        repeat (10) @(posedge clk_i);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, capture_end_i, paddr_i, pwdata_i} = '0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        apb(`REG_CTRL, 1'b0, 32'h0);
        check(q, `CTRL_RESET_VAL);
        apb(12'h100, 1'b0, 32'h0);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        $display("register test done");
        foreach (rows[i]) begin
            apb(`REG_CTRL, 1'b1, rows[i].ctrl);
            apb(`REG_ADDR_MIN, 1'b1, rows[i].amin);
            apb(`REG_ADDR_MAX, 1'b1, rows[i].amax);
            apb(`REG_DATA_HI, 1'b1, rows[i].dhi);
            run_seq(rows[i].seq);
            check(n_trig, rows[i].trig);
            check(n_err, rows[i].seq == 2);
            check(n_fld, rows[i].seq == 1 ? 4 : 2);
            $display("row %0d done", i);
        end
        apb(`REG_FRAME_INFO, 1'b0, 32'h0);
        check({q[16], q[9:0]}, {1'b1, 10'h050});
        apb(`REG_FIELD_INFO, 1'b0, 32'h0);
        check(q[7:0], 8'h3c);
        apb(`REG_FILT_CTRL, 1'b1, 32'h45);
        run_seq(0);
        check(n_frm, 0);
        apb(`REG_FILT_CTRL, 1'b1, 32'h05);
        run_seq(0);
        check(n_frm, 1);
        apb(`REG_CTRL, 1'b1, 32'h5);
        apb(`REG_DATA_HI, 1'b1, 32'h5a000000);
        apb(`REG_DATA_CFG, 1'b1, 32'h0101);
        run_seq(0);
        check(n_trig, 0);
        $display("filter test done");
        u_bus.start_c();
        u_bus.put_byte(8'ha0, 1'b0);
        capture_end_i <= 1'b1;
        @(posedge clk_i);
        capture_end_i <= 1'b0;
        apb(`REG_FRAME_INFO, 1'b0, 32'h0);
        check(q[22], 1'b1);
        u_bus.stop_c();
        apb(`REG_CTRL, 1'b1, 32'h2);
        rstn_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        apb(`REG_CTRL, 1'b0, 32'h0);
        check(q, `CTRL_RESET_VAL);
        $display("capture and reset test done");
        wrap_up();
    end
endmodule
bind i2c_bus_trigger_decoder i2c_bus_trigger_decoder_properties #(.PATTERN_BYTES(PATTERN_BYTES)) u_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .scl_i(scl_i), .sda_i(sda_i), .capture_end_i(capture_end_i), .trigger_o(trigger_o),
    .frame_valid_o(frame_valid_o), .field_valid_o(field_valid_o), .error_o(error_o));
`default_nettype wire
